// *** rtl/wdrc_top.sv ***
// Watchdog and system reset control: registers, keys, causes and timeouts
`timescale 1ns/1ps
module wdrc_top
    import wdrc_pkg::*;
#(
    parameter int unsigned         SLOW_DIV_P  = SLOW_DIV,
    parameter logic [WD_CNT_W-1:0] K_SHORT_P   = WD_K_SHORT,
    parameter logic [WD_CNT_W-1:0] K_MID_P     = WD_K_MID,
    parameter logic [WD_CNT_W-1:0] B_SHORT_P   = WD_B_SHORT,
    parameter logic [WD_CNT_W-1:0] B_MID_P     = WD_B_MID,
    parameter logic [WD_CNT_W-1:0] B_LONG_P    = WD_B_LONG
)
(
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              rstn_in,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [DATA_W-1:0] reg_rdata_out,
    // Reset sources
    input  wire logic              illegal_opcode_reset_source_req_in,
    input  wire logic              illegal_address_reset_source_req_in,
    input  wire logic              lvd_req_in,
    input  wire logic              loc_req_in,
    input  wire logic              debugger_forced_reset_req_in,
    // Operating modes
    input  wire logic              debug_mode_in,
    input  wire logic              stop_mode_in,
    // Reset pin
    input  wire logic              reset_pin_in,
    output logic                   reset_pin_out,
    output logic                   reset_pin_oe_out,
    // System reset
    output logic                   sys_reset_out
);

    // Sequencer signals
    logic                  in_reset;
    logic                  seq_sample;
    logic                  seq_pin_low;
    logic                  reset_req;

    // Option registers and locks
    logic [DATA_W-1:0]     opt1_q;
    logic [DATA_W-1:0]     opt2_q;
    logic                  lock1_q;
    logic                  lock2_q;
    logic [1:0]            tsel;
    logic                  bus_clk_sel;
    logic                  win_en;

    // Cause tracking
    logic [NUM_SOURCES-1:0] src_vec;
    logic [NUM_SOURCES-1:0] pending_q;
    logic [NUM_SOURCES-1:0] cause_q;

    // Service keys
    wdrc_key_t             key_q;
    logic                  wr_cause;
    logic                  wr_opt1_first;
    logic                  wr_opt2_first;
    logic                  key_bad;
    logic                  win_early;
    logic                  service;

    // Watchdog
    logic [DIV_W-1:0]      div_q;
    logic                  slow_tick;
    logic                  halt_mode;
    logic                  wd_enabled;
    logic                  wd_clear;
    logic                  wd_count_en;
    logic                  wd_timeout;
    logic [WD_CNT_W-1:0]   wd_limit;
    logic [WD_CNT_W-1:0]   wd_count;
    logic [WD_CNT_W-1:0]   win_start;
    logic                  win_mode;
    logic                  win_open;

    // Read path
    logic [DATA_W-1:0]     rdata_d;
    logic [DATA_W-1:0]     rdata_q;
    logic [DATA_W-1:0]     stat_vec;

    // Reset pin sequencer
    wdrc_seq u_seq (
        .clk_sys_in   (clk_sys_in),
        .rstn_in      (rstn_in),
        .req_in       (reset_req),
        .pin_level_in (reset_pin_in),
        .pin_oe_out   (reset_pin_oe_out),
        .in_reset_out (in_reset),
        .sample_out   (seq_sample),
        .pin_low_out  (seq_pin_low)
    );

    assign reset_pin_out = 1'b0;
    assign sys_reset_out = in_reset;

    // Option fields
    assign tsel        = opt1_q[OPT1_TSEL_HI:OPT1_TSEL_LO];
    assign bus_clk_sel = opt2_q[OPT2_CLKSEL];
    assign win_en      = opt2_q[OPT2_WIN];
    assign wd_enabled  = (tsel != TSEL_OFF);

    // Bus write decode; bus writes are ignored while the system is in reset, reads are still served
    assign wr_cause      = reg_wr_in && !in_reset && (reg_addr_in == ADDR_CAUSE);
    assign wr_opt1_first = reg_wr_in && !in_reset && (reg_addr_in == ADDR_OPT1) && !lock1_q;
    assign wr_opt2_first = reg_wr_in && !in_reset && (reg_addr_in == ADDR_OPT2) && !lock2_q;

    // Write-once option registers, back to defaults on every system reset
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || in_reset)
        begin
            opt1_q  <= OPT1_RST;
            lock1_q <= 1'b0;
        end
        else if (wr_opt1_first)
        begin
            opt1_q  <= reg_wdata_in & OPT1_MASK;
            lock1_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || in_reset)
        begin
            opt2_q  <= OPT2_RST;
            lock2_q <= 1'b0;
        end
        else if (wr_opt2_first)
        begin
            opt2_q  <= reg_wdata_in & OPT2_MASK;
            lock2_q <= 1'b1;
        end
    end

    // Timeout length for the selected clock and select code
    always_comb
    begin
        wd_limit = WD_K_LONG;
        if (bus_clk_sel)
        begin
            case (tsel)
                TSEL_SHORT: wd_limit = B_SHORT_P;
                TSEL_MID:   wd_limit = B_MID_P;
                TSEL_LONG:  wd_limit = B_LONG_P;
                default:    wd_limit = B_LONG_P;
            endcase
        end
        else
        begin
            case (tsel)
                TSEL_SHORT: wd_limit = K_SHORT_P;
                TSEL_MID:   wd_limit = K_MID_P;
                TSEL_LONG:  wd_limit = WD_K_LONG;
                default:    wd_limit = WD_K_LONG;
            endcase
        end
    end

    // Window opens for the final quarter, only with the bus clock
    assign win_start = wd_limit - (wd_limit >> 2);
    assign win_mode  = bus_clk_sel && win_en && wd_enabled;
    assign win_open  = (wd_count >= win_start);

    // Service key checks
    assign key_bad   = wr_cause && (reg_wdata_in != KEY_FIRST)
                       && (reg_wdata_in != KEY_SECOND);
    assign win_early = wr_cause && !key_bad && win_mode && !win_open;
    assign service   = wr_cause && (reg_wdata_in == KEY_SECOND)
                       && (key_q == KEY_ARMED) && !win_early;

    // Key sequence tracking
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || in_reset)
            key_q <= KEY_IDLE;
        else if (wr_cause)
        begin
            if (reg_wdata_in == KEY_FIRST)
                key_q <= KEY_ARMED;
            else
                key_q <= KEY_IDLE;
        end
    end

    // Internal slow clock enable from the system clock
    assign slow_tick = (div_q == DIV_W'(SLOW_DIV_P - 1));

    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || slow_tick)
            div_q <= '0;
        else
            div_q <= div_q + 16'h0001;
    end

    // Counter control by clock choice and low-power or debug mode
    assign halt_mode   = debug_mode_in || stop_mode_in;
    assign wd_count_en = bus_clk_sel ? !halt_mode
                                     : (slow_tick && !halt_mode);
    assign wd_clear    = in_reset || wr_opt1_first || wr_opt2_first
                         || service
                         || (!bus_clk_sel && halt_mode);

    wdrc_wdog u_wdog (
        .clk_sys_in  (clk_sys_in),
        .rstn_in     (rstn_in),
        .clear_in    (wd_clear),
        .count_en_in (wd_count_en),
        .enable_in   (wd_enabled),
        .limit_in    (wd_limit),
        .count_out   (wd_count),
        .timeout_out (wd_timeout)
    );

    // Reset sources; the debugger request has no flag of its own
    assign src_vec[CAUSE_POR]  = 1'b0;
    assign src_vec[CAUSE_PIN]  = !reset_pin_in;
    assign src_vec[CAUSE_WDOG] = wd_timeout || key_bad || win_early;
    assign src_vec[CAUSE_ILLEGAL_OPCODE_RESET_SOURCE] = illegal_opcode_reset_source_req_in;
    assign src_vec[CAUSE_ILLEGAL_ADDRESS_RESET_SOURCE] = illegal_address_reset_source_req_in;
    assign src_vec[CAUSE_LOC]  = loc_req_in;
    assign src_vec[CAUSE_LVD]  = lvd_req_in;
    assign src_vec[0]          = 1'b0;

    assign reset_req = !in_reset && ((|src_vec) || debugger_forced_reset_req_in);

    // Capture pending cause as the reset starts
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            pending_q <= POR_MASK;
        else if (reset_req)
            pending_q <= src_vec;
    end

    // Cause register, set only by hardware at the pin sample
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            cause_q <= CAUSE_RST;
        else if (seq_sample)
            cause_q <= seq_pin_low ? PIN_MASK : pending_q;
    end

    // Status vector
    always_comb
    begin
        stat_vec              = '0;
        stat_vec[STAT_EN]     = wd_enabled;
        stat_vec[STAT_BUSCLK] = bus_clk_sel;
        stat_vec[STAT_WMODE]  = win_mode;
        stat_vec[STAT_WOPEN]  = win_mode && win_open;
        stat_vec[STAT_ARMED]  = (key_q == KEY_ARMED);
        stat_vec[STAT_LOCK1]  = lock1_q;
        stat_vec[STAT_LOCK2]  = lock2_q;
    end

    // Read mux, unmapped addresses read zero
    always_comb
    begin
        rdata_d = '0;
        case (reg_addr_in)
            ADDR_CAUSE: rdata_d = cause_q;
            ADDR_OPT1:  rdata_d = opt1_q;
            ADDR_OPT2:  rdata_d = opt2_q;
            ADDR_STAT:  rdata_d = stat_vec;
            ADDR_CNT0:  rdata_d = wd_count[7:0];
            ADDR_CNT1:  rdata_d = wd_count[15:8];
            ADDR_CNT2:  rdata_d = {4'h0, wd_count[19:16]};
            default:    rdata_d = '0;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            rdata_q <= '0;
        else if (reg_rd_in)
            rdata_q <= rdata_d;
        else
            rdata_q <= '0;
    end

    assign reg_rdata_out = rdata_q;

endmodule : wdrc_top

// *** rtl/wdrc_pkg.sv ***
// Package for the watchdog and reset control block: map, fields, counts and states
package wdrc_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_CAUSE = 8'h00;
    localparam logic [7:0] ADDR_OPT1  = 8'h01;
    localparam logic [7:0] ADDR_OPT2  = 8'h02;
    localparam logic [7:0] ADDR_STAT  = 8'h03;
    localparam logic [7:0] ADDR_CNT0  = 8'h04;
    localparam logic [7:0] ADDR_CNT1  = 8'h05;
    localparam logic [7:0] ADDR_CNT2  = 8'h06;

    // Service keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Option register fields and reset values
    localparam int         OPT1_TSEL_LO = 6;
    localparam int         OPT1_TSEL_HI = 7;
    localparam logic [7:0] OPT1_MASK    = 8'hC0;
    localparam logic [7:0] OPT1_RST     = 8'hC0;
    localparam int         OPT2_CLKSEL  = 7;
    localparam int         OPT2_WIN     = 6;
    localparam logic [7:0] OPT2_MASK    = 8'hC0;
    localparam logic [7:0] OPT2_RST     = 8'h00;
    localparam logic [1:0] TSEL_OFF     = 2'h0;
    localparam logic [1:0] TSEL_SHORT   = 2'h1;
    localparam logic [1:0] TSEL_MID     = 2'h2;
    localparam logic [1:0] TSEL_LONG    = 2'h3;

    // Reset cause flag positions
    localparam int         NUM_SOURCES  = 8;
    localparam int         CAUSE_POR    = 7;
    localparam int         CAUSE_PIN    = 6;
    localparam int         CAUSE_WDOG   = 5;
    localparam int         CAUSE_ILLEGAL_OPCODE_RESET_SOURCE   = 4;
    localparam int         CAUSE_ILLEGAL_ADDRESS_RESET_SOURCE   = 3;
    localparam int         CAUSE_LOC    = 2;
    localparam int         CAUSE_LVD    = 1;
    localparam logic [7:0] CAUSE_RST    = 8'h00;
    localparam logic [7:0] POR_MASK     = 8'h80;
    localparam logic [7:0] PIN_MASK     = 8'h40;

    // Status register bit positions
    localparam int STAT_EN     = 0;
    localparam int STAT_BUSCLK = 1;
    localparam int STAT_WMODE  = 2;
    localparam int STAT_WOPEN  = 3;
    localparam int STAT_ARMED  = 4;
    localparam int STAT_LOCK1  = 5;
    localparam int STAT_LOCK2  = 6;

    // Reset pin timing in bus cycles
    localparam int         SEQ_CNT_W        = 7;
    localparam logic [6:0] PIN_DRIVE_CYCLES = 7'h42;
    localparam logic [6:0] PIN_SETTLE_CYCLES = 7'h26;

    // Watchdog counter and timeouts in watchdog clock cycles
    localparam int          WD_CNT_W      = 20;
    localparam logic [19:0] WD_K_LONG     = 20'h0_0400;
    localparam logic [19:0] WD_K_SHORT    = 20'h0_0020;
    localparam logic [19:0] WD_K_MID      = 20'h0_0100;
    localparam logic [19:0] WD_B_SHORT    = 20'h0_2000;
    localparam logic [19:0] WD_B_MID      = 20'h1_0000;
    localparam logic [19:0] WD_B_LONG     = 20'h4_0000;

    // Internal slow clock derived from the system clock
    localparam int CLK_HZ  = 50_000_000;
    localparam int SLOW_HZ = 1_000;
    localparam int DIV_W   = 16;
    localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;

    // Reset sequencer states
    typedef enum logic [1:0] {
        SEQ_RUN    = 2'b00,
        SEQ_DRIVE  = 2'b01,
        SEQ_SETTLE = 2'b10,
        SEQ_HOLD   = 2'b11
    } wdrc_seq_t;

    // Service key states
    typedef enum logic [0:0] {
        KEY_IDLE  = 1'b0,
        KEY_ARMED = 1'b1
    } wdrc_key_t;

endpackage : wdrc_pkg

// *** rtl/wdrc_seq.sv ***
// Reset pin sequencer: drives the pin, waits, samples it
`timescale 1ns/1ps
module wdrc_seq
    import wdrc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rstn_in,
    // Request and pin level
    input  wire logic req_in,
    input  wire logic pin_level_in,
    // Sequence outputs
    output logic      pin_oe_out,
    output logic      in_reset_out,
    output logic      sample_out,
    output logic      pin_low_out
);

    wdrc_seq_t            state_q;
    logic [SEQ_CNT_W-1:0] cnt_q;
    logic                 drive_last;
    logic                 settle_last;

    assign drive_last  = (cnt_q == PIN_DRIVE_CYCLES - 7'h01);
    assign settle_last = (cnt_q == PIN_SETTLE_CYCLES - 7'h01);

    // State and cycle counter
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
        begin
            state_q <= SEQ_DRIVE;
            cnt_q   <= '0;
        end
        else
        begin
            case (state_q)
                SEQ_RUN:
                begin
                    cnt_q <= '0;
                    if (req_in)
                        state_q <= SEQ_DRIVE;
                end
                SEQ_DRIVE:
                begin
                    if (drive_last)
                    begin
                        state_q <= SEQ_SETTLE;
                        cnt_q   <= '0;
                    end
                    else
                        cnt_q <= cnt_q + 7'h01;
                end
                SEQ_SETTLE:
                begin
                    if (settle_last)
                    begin
                        state_q <= pin_level_in ? SEQ_RUN : SEQ_HOLD;
                        cnt_q   <= '0;
                    end
                    else
                        cnt_q <= cnt_q + 7'h01;
                end
                SEQ_HOLD:
                begin
                    if (pin_level_in)
                        state_q <= SEQ_RUN;
                end
                default:
                begin
                    state_q <= SEQ_DRIVE;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    assign pin_oe_out   = (state_q == SEQ_DRIVE);
    assign in_reset_out = (state_q != SEQ_RUN);
    assign sample_out   = (state_q == SEQ_SETTLE) && settle_last;
    assign pin_low_out  = !pin_level_in;

endmodule : wdrc_seq

// *** rtl/wdrc_wdog.sv ***
// Watchdog counter with clear, count enable and timeout limit
`timescale 1ns/1ps
module wdrc_wdog
    import wdrc_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                rstn_in,
    // Control
    input  wire logic                clear_in,
    input  wire logic                count_en_in,
    input  wire logic                enable_in,
    input  wire logic [WD_CNT_W-1:0] limit_in,
    // State
    output logic      [WD_CNT_W-1:0] count_out,
    output logic                     timeout_out
);

    logic [WD_CNT_W-1:0] count_q;
    logic                at_limit;

    assign at_limit    = (count_q == limit_in - 20'h0_0001);
    assign timeout_out = enable_in && count_en_in && at_limit && !clear_in;
    assign count_out   = count_q;

    // Counter
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || clear_in)
            count_q <= '0;
        else if (enable_in && count_en_in)
            count_q <= at_limit ? '0 : count_q + 20'h0_0001;
    end

endmodule : wdrc_wdog

// *** tb/wdrc_top_assertions.sv ***
// Checker for the watchdog and reset control block
`timescale 1ns/1ps
module wdrc_top_chk
    import wdrc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_in,
    input  wire logic              rstn_in,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    // Reset sources
    input  wire logic              illegal_opcode_reset_source_req_in,
    input  wire logic              illegal_address_reset_source_req_in,
    input  wire logic              lvd_req_in,
    input  wire logic              loc_req_in,
    input  wire logic              debugger_forced_reset_req_in,
    // Reset pin and system reset
    input  wire logic              reset_pin_in,
    input  wire logic              reset_pin_out,
    input  wire logic              reset_pin_oe_out,
    input  wire logic              sys_reset_out
);
    logic [7:0] run_q;
    logic [7:0] set_q;
    logic       ok_q;
    logic       src_w;
    assign src_w = illegal_opcode_reset_source_req_in | illegal_address_reset_source_req_in | lvd_req_in | loc_req_in | debugger_forced_reset_req_in;
    // Length of the present pin drive
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            run_q <= 8'h00;
        else if (reset_pin_oe_out)
            run_q <= run_q + 8'h01;
        else
            run_q <= 8'h00;
    end
    // First drive after power-on is not measured
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in)
            ok_q <= 1'b0;
        else if (!reset_pin_oe_out)
            ok_q <= 1'b1;
    end
    // Length of the settle phase
    always_ff @(posedge clk_sys_in)
    begin
        if (!rstn_in || !sys_reset_out || reset_pin_oe_out)
            set_q <= 8'h00;
        else if (set_q != 8'hFF)
            set_q <= set_q + 8'h01;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    pin_drive_a: assert property ($fell(reset_pin_oe_out) && ok_q |-> run_q == 8'h42)
        else $error("Reset pin drive length wrong");
    pin_low_a: assert property (reset_pin_oe_out |-> !reset_pin_out)
        else $error("Reset pin driven high");
    settle_len_a: assert property ($fell(sys_reset_out) |-> set_q >= 8'h26)
        else $error("Settle phase too short");
    pin_hold_a: assert property (sys_reset_out && !reset_pin_oe_out && !reset_pin_in |=> sys_reset_out)
        else $error("Left reset with pin low");
    clean_exit_a: assert property ($fell(sys_reset_out) |-> !reset_pin_oe_out && reset_pin_in)
        else $error("Left reset while pin driven");
    src_reset_a: assert property (!sys_reset_out && src_w |-> ##[1:3] sys_reset_out)
        else $error("Reset source ignored");
    ext_reset_a: assert property (!sys_reset_out && !reset_pin_in |-> ##[1:4] sys_reset_out)
        else $error("External pin reset ignored");
    bad_key_a: assert property (reg_wr_in && reg_addr_in == ADDR_CAUSE && !sys_reset_out && reg_wdata_in != KEY_FIRST && reg_wdata_in != KEY_SECOND |=> sys_reset_out && reset_pin_oe_out)
        else $error("Bad key did not reset");
endmodule : wdrc_top_chk

bind wdrc_top wdrc_top_chk u_chk (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .illegal_opcode_reset_source_req_in(illegal_opcode_reset_source_req_in),
    .illegal_address_reset_source_req_in(illegal_address_reset_source_req_in), .lvd_req_in(lvd_req_in), .loc_req_in(loc_req_in),
    .debugger_forced_reset_req_in(debugger_forced_reset_req_in), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_out(reset_pin_oe_out), .sys_reset_out(sys_reset_out));

// *** tb/tb_wdrc_top.sv ***
// Testbench for the watchdog and reset control block
`timescale 1ns/1ps
module tb_wdrc_top;
    import wdrc_pkg::*;
    localparam logic [7:0] SRC_CAUSE [5] = '{8'h10, 8'h08, 8'h02, 8'h04, 8'h00};
    localparam int         LIM [6] = '{16, 32, 64, 8 * 4, WD_K_MID * 4, WD_K_LONG * 4};
    logic       clk_sys_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [4:0] src = 5'h00;
    logic       dbg = 1'b0;
    logic       stp = 1'b0;
    logic       ext_low = 1'b0;
    logic [7:0] rdata;
    logic       pin_out;
    logic       pin_oe;
    logic       sys_rst;
    logic       pin_w;
    logic [7:0] rnd = 8'h02;
    logic [7:0] d;
    int         failures = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         n;
    int         i;
    // Pulled-up reset pin, low when driven or held externally
    assign pin_w = !(pin_oe && !pin_out) && !ext_low;
    always #10 clk_sys_in = ~clk_sys_in;

    wdrc_top #(.SLOW_DIV_P(4), .K_SHORT_P(20'h0_0008),
        .B_SHORT_P(20'h0_0010), .B_MID_P(20'h0_0020), .B_LONG_P(20'h0_0040)) DUT (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .illegal_opcode_reset_source_req_in(src[0]), .illegal_address_reset_source_req_in(src[1]), .lvd_req_in(src[2]),
        .loc_req_in(src[3]), .debugger_forced_reset_req_in(src[4]), .debug_mode_in(dbg),
        .stop_mode_in(stp), .reset_pin_in(pin_w), .reset_pin_out(pin_out),
        .reset_pin_oe_out(pin_oe), .sys_reset_out(sys_rst));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys_in);
        wr    <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a);
        @(posedge clk_sys_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_in);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task expect_reg(input logic [7:0] a, input logic [7:0] e);
        rd_reg(a);
        check(d, e);
    endtask : expect_reg

    // Waits out a reset, measuring drive and settle phases
    task wait_run(input bit exact);
        int nd;
        int ns;
        int t;
        nd = 0;
        ns = 0;
        t = 0;
        // Let the edge that starts a reset settle before looking at it
        #1;
        while (sys_rst !== 1'b1 && t < 8)
        begin
            @(posedge clk_sys_in);
            #1 t++;
        end
        while (sys_rst === 1'b1 && t < 6000)
        begin
            if (pin_oe === 1'b1)
                nd++;
            else
                ns++;
            @(posedge clk_sys_in);
            #1 t++;
        end
        if (exact)
        begin
            check(nd, 66);
            check(ns == 38 || ns == 39, 1);
        end
    endtask : wait_run

    task bad_key;
        rnd = lfsr(rnd);
        while (rnd == KEY_FIRST || rnd == KEY_SECOND)
            rnd = lfsr(rnd);
        wr_reg(ADDR_CAUSE, rnd);
        #1 check(sys_rst, 1'b1);
        wait_run(1'b1);
        expect_reg(ADDR_CAUSE, 8'h20);
    endtask : bad_key

    task cfg(input logic [7:0] o1, input logic [7:0] o2);
        wr_reg(ADDR_OPT1, o1);
        wr_reg(ADDR_OPT2, o2);
    endtask : cfg

    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            end_sim;
        end
    end

    initial
    begin
        repeat (16) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        wait_run(1'b0);
        expect_reg(ADDR_CAUSE, POR_MASK);
        expect_reg(ADDR_OPT1, OPT1_RST);
        expect_reg(ADDR_OPT2, OPT2_RST);
        expect_reg(8'h7F, 8'h00);
        rd_reg(ADDR_STAT);
        check(d[STAT_EN], 1'b1);
        repeat (40) @(posedge clk_sys_in);
        wr_reg(ADDR_CAUSE, KEY_FIRST);
        wr_reg(ADDR_CAUSE, KEY_SECOND);
        rd_reg(ADDR_CNT0);
        check(d <= 8'h01, 1'b1);
        expect_reg(ADDR_CAUSE, POR_MASK);
        bad_key;
        $display("Test keys done");
        for (i = 0; i < 5; i++)
        begin
            @(posedge clk_sys_in);
            src <= 5'h01 << i;
            @(posedge clk_sys_in);
            src <= 5'h00;
            wait_run(1'b1);
            expect_reg(ADDR_CAUSE, SRC_CAUSE[i]);
        end
        ext_low <= 1'b1;
        repeat (150) @(posedge clk_sys_in);
        #1 check(sys_rst, 1'b1);
        ext_low <= 1'b0;
        wait_run(1'b0);
        expect_reg(ADDR_CAUSE, PIN_MASK);
        $display("Test sources done");
        for (i = 0; i < 6; i++)
        begin
            cfg(8'((i % 3) + 1) << 6, (i < 3) ? 8'h80 : 8'h00);
            wr_reg(ADDR_OPT1, 8'h00);
            expect_reg(ADDR_OPT1, 8'((i % 3) + 1) << 6);
            n = 4;
            while (sys_rst !== 1'b1 && n < 6000)
            begin
                @(posedge clk_sys_in);
                #1 n++;
            end
            check(n >= LIM[i] - 5 && n <= LIM[i] + 6, 1'b1);
            wait_run(1'b1);
            expect_reg(ADDR_CAUSE, 8'h20);
        end
        $display("Test timeouts done");
        cfg(8'h00, 8'h80);
        repeat (200) @(posedge clk_sys_in);
        #1 check(sys_rst, 1'b0);
        rd_reg(ADDR_STAT);
        check(d[STAT_EN], 1'b0);
        bad_key;
        cfg(8'hC0, 8'hC0);
        wr_reg(ADDR_CAUSE, KEY_FIRST);
        wait_run(1'b1);
        expect_reg(ADDR_CAUSE, 8'h20);
        cfg(8'hC0, 8'hC0);
        repeat (52) @(posedge clk_sys_in);
        wr_reg(ADDR_CAUSE, KEY_FIRST);
        wr_reg(ADDR_CAUSE, KEY_SECOND);
        #1 check(sys_rst, 1'b0);
        rd_reg(ADDR_CNT0);
        check(d <= 8'h04, 1'b1);
        bad_key;
        cfg(8'h40, 8'h40);
        wr_reg(ADDR_CAUSE, KEY_FIRST);
        wr_reg(ADDR_CAUSE, KEY_SECOND);
        #1 check(sys_rst, 1'b0);
        bad_key;
        $display("Test window done");
        cfg(8'hC0, 8'h80);
        repeat (10) @(posedge clk_sys_in);
        dbg <= 1'b1;
        rd_reg(ADDR_CNT0);
        n = d;
        repeat (100) @(posedge clk_sys_in);
        expect_reg(ADDR_CNT0, 8'(n));
        check(sys_rst, 1'b0);
        dbg <= 1'b0;
        bad_key;
        cfg(8'h40, 8'h00);
        repeat (10) @(posedge clk_sys_in);
        stp <= 1'b1;
        repeat (100) @(posedge clk_sys_in);
        expect_reg(ADDR_CNT0, 8'h00);
        check(sys_rst, 1'b0);
        stp <= 1'b0;
        bad_key;
        $display("Test modes done");
        end_sim;
    end
endmodule : tb_wdrc_top
